/* ccm_pkg.sv */
/*
 package for the codec clock, reset and mute control block: timing
 counts, ratio encodings, mode types and the sample carrier struct.
 assumes one 250 MHz clock domain; nothing here has state.
*/
`default_nettype none
package ccm_pkg;
   localparam int CLK_MHZ = 250;
   localparam int ZERO_RUN = 512;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] ZERO_LIMIT = CNT_W'(ZERO_RUN);
   localparam int CH_NUM = 6;
   localparam int SMP_W = 24;
   localparam int RATIO_W = 10;
   // clock-ratio field codes
   localparam logic [1:0] RATIO_0 = 2'h0;
   localparam logic [1:0] RATIO_1 = 2'h1;
   localparam logic [1:0] RATIO_2 = 2'h2;
   localparam logic [1:0] RATIO_3 = 2'h3;
   // master clocks per frame, base rate mode
   localparam logic [RATIO_W-1:0] BRM_R0 = 10'h080;
   localparam logic [RATIO_W-1:0] BRM_R1 = 10'h100;
   localparam logic [RATIO_W-1:0] BRM_R2 = 10'h180;
   localparam logic [RATIO_W-1:0] BRM_R3 = 10'h200;
   // master clocks per frame, high rate mode
   localparam logic [RATIO_W-1:0] HRM_R0 = 10'h040;
   localparam logic [RATIO_W-1:0] HRM_R1 = 10'h080;
   localparam logic [RATIO_W-1:0] HRM_R2 = 10'h0c0;
   localparam logic [RATIO_W-1:0] HRM_R3 = 10'h100;
   localparam logic [6:0] ADDR_BASE = 7'h48;
   typedef enum logic [0:0] {
      CCM_TWO_WIRE = 1'b0,
      CCM_FOUR_WIRE = 1'b1
   } ccm_port_mode_t;
   typedef struct packed {
      logic valid;
      logic [CH_NUM-1:0][SMP_W-1:0] data;
   } ccm_frame_t;
   typedef struct packed {
      logic master_mode;
      logic high_rate_mode;
      logic [1:0] clock_ratio_select;
      logic [7:0] bit_clock_div;
   } ccm_clk_cfg_t;
endpackage : ccm_pkg
`default_nettype wire

/* ccm_core.sv */
/*
 clock direction, ratio check, bit clock divider, control port pin
 steering, port mode strap and mute output of the codec.
 assumes clk is the master clock domain and all pins are synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module ccm_core #(
   parameter int BIT_DIV_W = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire ccm_pkg::ccm_clk_cfg_t clk_cfg,
   input wire logic mclk_present,
   input wire logic frame_select_clock_in,
   output logic frame_select_clock_out,
   output logic frame_select_clock_oe_n,
   output logic bit_clock_out,
   output logic bit_clock_oe_n,
   output logic frame_left,
   output logic pair_strobe,
   input wire logic audio_serial_out_in,
   output logic audio_serial_out_oe_n,
   output ccm_pkg::ccm_port_mode_t port_mode,
   input wire logic control_port_clock,
   input wire logic control_data_in,
   input wire logic control_data_drive_low,
   output logic control_data_out,
   output logic control_data_oe_n,
   output logic control_data_sample,
   input wire logic address_select_lsb,
   output logic [6:0] bus_address,
   output logic control_port_enable,
   output logic core_enable,
   output logic low_power,
   input wire logic power_up_done,
   input wire logic power_down,
   input wire logic soft_mute,
   input wire logic zero_mute_enable,
   input wire ccm_pkg::ccm_frame_t dac_frame,
   output logic ratio_error,
   output logic zero_muted,
   output logic mute_output_n
);
   logic [ccm_pkg::RATIO_W-1:0] ratio, next_ratio;
   logic [ccm_pkg::RATIO_W-1:0] frame_cnt, next_frame_cnt;
   logic [ccm_pkg::RATIO_W-1:0] ref_ratio;
   logic fs_prev, next_fs_prev;
   logic next_ratio_error;
   logic seen_edge, next_seen_edge;
   logic [BIT_DIV_W-1:0] bdiv, next_bdiv;
   logic next_bit_clock_out;
   logic next_frame_select_clock_out;
   logic [ccm_pkg::CNT_W-1:0] zcnt, next_zcnt;
   logic next_zero_muted;
   logic strap_done, next_strap_done;
   ccm_pkg::ccm_port_mode_t next_port_mode;
   logic control_port_clock_prev, next_control_port_clock_prev;
   logic next_mute_output_n;
   logic next_frame_left, next_pair_strobe;
   logic fs_now, fs_rise, fs_fall, all_zero;
   logic next_ctl_sample;
   logic [ccm_pkg::CH_NUM-1:0] ch_zero;

   // ratio lookup from mode and field
   always_comb begin
      ref_ratio = ccm_pkg::BRM_R1;
      if (clk_cfg.high_rate_mode) begin
         case (clk_cfg.clock_ratio_select)
            ccm_pkg::RATIO_0: ref_ratio = ccm_pkg::HRM_R0;
            ccm_pkg::RATIO_1: ref_ratio = ccm_pkg::HRM_R1;
            ccm_pkg::RATIO_2: ref_ratio = ccm_pkg::HRM_R2;
            default: ref_ratio = ccm_pkg::HRM_R3;
         endcase
      end else begin
         case (clk_cfg.clock_ratio_select)
            ccm_pkg::RATIO_0: ref_ratio = ccm_pkg::BRM_R0;
            ccm_pkg::RATIO_1: ref_ratio = ccm_pkg::BRM_R1;
            ccm_pkg::RATIO_2: ref_ratio = ccm_pkg::BRM_R2;
            default: ref_ratio = ccm_pkg::BRM_R3;
         endcase
      end
   end

   // frame clock source and ratio measurement
   always_comb begin
      fs_now = clk_cfg.master_mode ? frame_select_clock_out
                                   : frame_select_clock_in;
      fs_rise = fs_now && !fs_prev;
      fs_fall = !fs_now && fs_prev;
      next_fs_prev = fs_now;
      next_frame_cnt = frame_cnt + 1'b1;
      next_ratio = ratio;
      next_ratio_error = ratio_error;
      next_seen_edge = seen_edge;
      next_frame_select_clock_out = frame_select_clock_out;
      // master frame clock set at ratio-2: its output register adds one
      // clock and the rise restarts the count, so a master frame is the ratio
      if (clk_cfg.master_mode &&
          frame_cnt == ref_ratio - 2'h2) begin
         next_frame_select_clock_out = 1'b1;
      end else if (clk_cfg.master_mode &&
                   frame_cnt == (ref_ratio >> 1) - 2'h2) begin
         next_frame_select_clock_out = 1'b0;
      end
      if (fs_rise) begin
         next_frame_cnt = '0;
         next_ratio = frame_cnt + 1'b1;
         next_seen_edge = 1'b1;
         // a slave clock off the selected multiple mutes the outputs
         next_ratio_error = seen_edge &&
                            (frame_cnt + 1'b1 != ref_ratio);
      end else if (frame_cnt == '1) begin
         next_ratio_error = 1'b1;
      end
      if (clk_cfg.master_mode && frame_cnt == ref_ratio - 1'b1) begin
         next_frame_cnt = '0;
      end
   end

   // left low, right high; a pair completes on the falling edge
   always_comb begin
      next_frame_left = !fs_now;
      next_pair_strobe = fs_fall;
   end

   // bit clock divider, master only
   always_comb begin
      next_bdiv = bdiv + 1'b1;
      next_bit_clock_out = bit_clock_out;
      if (!clk_cfg.master_mode || fs_rise) begin
         next_bdiv = '0;
         next_bit_clock_out = 1'b0;
      end else if (bdiv == clk_cfg.bit_clock_div[BIT_DIV_W-1:0]) begin
         next_bdiv = '0;
         next_bit_clock_out = !bit_clock_out;
      end
   end

   // mode strap: caught on the first clock after reset release
   always_comb begin
      next_strap_done = 1'b1;
      next_port_mode = port_mode;
      if (!strap_done) begin
         next_port_mode = audio_serial_out_in ? ccm_pkg::CCM_FOUR_WIRE
                                              : ccm_pkg::CCM_TWO_WIRE;
      end
   end

   // one zero flag per converter input
   for (genvar ch = 0; ch < ccm_pkg::CH_NUM; ch++) begin : g_ch_zero
      assign ch_zero[ch] = (dac_frame.data[ch] == '0);
   end

   // zero detect across all channels
   always_comb begin
      all_zero = &ch_zero;
      next_zcnt = zcnt;
      if (dac_frame.valid) begin
         if (!all_zero) begin
            next_zcnt = '0;
         end else if (zcnt != ccm_pkg::ZERO_LIMIT) begin
            next_zcnt = zcnt + 1'b1;
         end
      end
      next_zero_muted = zero_mute_enable &&
                        next_zcnt == ccm_pkg::ZERO_LIMIT;
   end

   // mute output, low means muted
   always_comb begin
      next_mute_output_n = !(!power_up_done || power_down ||
                             !mclk_present || next_ratio_error ||
                             soft_mute || next_zero_muted);
   end

   // control port edge tracking, samples only while the port is enabled
   always_comb begin
      next_control_port_clock_prev = control_port_clock;
      next_ctl_sample = control_port_enable &&
                        control_port_clock && !control_port_clock_prev;
   end

   // pin steering for the control port
   always_comb begin
      control_data_out = 1'b0;
      control_data_oe_n = !(port_mode == ccm_pkg::CCM_TWO_WIRE &&
                            control_data_drive_low && strap_done);
      bus_address = {ccm_pkg::ADDR_BASE[6:1], address_select_lsb};
      control_port_enable = strap_done &&
                            (port_mode == ccm_pkg::CCM_TWO_WIRE ||
                             !address_select_lsb);
      frame_select_clock_oe_n = !clk_cfg.master_mode;
      bit_clock_oe_n = !clk_cfg.master_mode;
      // strap pin stays an input until the mode is caught
      audio_serial_out_oe_n = !strap_done;
      core_enable = strap_done;
      low_power = !strap_done;
   end

   // whole state back to defaults while reset is low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ratio <= '0;
         frame_cnt <= '0;
         fs_prev <= 1'b0;
         ratio_error <= 1'b0;
         seen_edge <= 1'b0;
         frame_select_clock_out <= 1'b0;
      end else begin
         ratio <= next_ratio;
         frame_cnt <= next_frame_cnt;
         fs_prev <= next_fs_prev;
         ratio_error <= next_ratio_error;
         seen_edge <= next_seen_edge;
         frame_select_clock_out <= next_frame_select_clock_out;
      end
   end

   // frame half and pair strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_left <= 1'b1;
         pair_strobe <= 1'b0;
      end else begin
         frame_left <= next_frame_left;
         pair_strobe <= next_pair_strobe;
      end
   end

   // bit clock divider
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bdiv <= '0;
         bit_clock_out <= 1'b0;
      end else begin
         bdiv <= next_bdiv;
         bit_clock_out <= next_bit_clock_out;
      end
   end

   // port mode strap
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_done <= 1'b0;
         port_mode <= ccm_pkg::CCM_TWO_WIRE;
      end else begin
         strap_done <= next_strap_done;
         port_mode <= next_port_mode;
      end
   end

   // zero run
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         zcnt <= '0;
         zero_muted <= 1'b0;
      end else begin
         zcnt <= next_zcnt;
         zero_muted <= next_zero_muted;
      end
   end

   // mute output, held low through reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mute_output_n <= 1'b0;
      end else begin
         mute_output_n <= next_mute_output_n;
      end
   end

   // control clock edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         control_port_clock_prev <= 1'b0;
         control_data_sample <= 1'b0;
      end else begin
         control_port_clock_prev <= next_control_port_clock_prev;
         control_data_sample <= next_ctl_sample;
      end
   end
endmodule : ccm_core
`default_nettype wire

/* ccm_core_monitor.sv */
/*
 checker for ccm_core: pin directions, address, mute causes, zero run.
 assumes one clock domain and the bind below.
*/
`timescale 1ns/100ps
`default_nettype none
module ccm_core_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire ccm_pkg::ccm_clk_cfg_t clk_cfg,
   input wire logic mclk_present,
   input wire logic power_down,
   input wire logic soft_mute,
   input wire logic zero_mute_enable,
   input wire ccm_pkg::ccm_frame_t dac_frame,
   input wire logic frame_select_clock_oe_n,
   input wire logic bit_clock_oe_n,
   input wire ccm_pkg::ccm_port_mode_t port_mode,
   input wire logic control_data_oe_n,
   input wire logic address_select_lsb,
   input wire logic [6:0] bus_address,
   input wire logic zero_muted,
   input wire logic mute_output_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [ccm_pkg::CNT_W-1:0] zrun;
   logic [ccm_pkg::CNT_W-1:0] next_zrun;
   wire logic zf = dac_frame.valid && (dac_frame.data == '0);
   wire logic nzf = dac_frame.valid && (dac_frame.data != '0);
   // own run count, kept apart from the design's to catch off-by-one
   always_comb begin
      next_zrun = zrun;
      if (nzf) begin
         next_zrun = '0;
      end else if (zf && zrun != ccm_pkg::ZERO_LIMIT) begin
         next_zrun = zrun + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         zrun <= '0;
      end else begin
         zrun <= next_zrun;
      end
   end
   sequence s_zero_last;
      zf && zero_mute_enable && zrun == ccm_pkg::ZERO_LIMIT - 1'b1;
   endsequence
   sequence s_live_muted;
      nzf && zero_muted;
   endsequence
   property p_fs_dir;
      frame_select_clock_oe_n == !clk_cfg.master_mode;
   endproperty
   a_fs_dir: assert property (p_fs_dir) else $error("fclk dir");
   property p_bclk_dir;
      bit_clock_oe_n == !clk_cfg.master_mode;
   endproperty
   a_bclk_dir: assert property (p_bclk_dir) else $error("bclk oe");
   property p_four_in;
      port_mode == ccm_pkg::CCM_FOUR_WIRE |-> control_data_oe_n;
   endproperty
   a_four_in: assert property (p_four_in) else $error("data drv");
   property p_addr;
      bus_address == {ccm_pkg::ADDR_BASE[6:1], address_select_lsb};
   endproperty
   a_addr: assert property (p_addr) else $error("address");
   property p_soft;
      soft_mute |=> !mute_output_n;
   endproperty
   a_soft: assert property (p_soft) else $error("soft mute");
   property p_fault;
      !mclk_present || power_down |=> !mute_output_n;
   endproperty
   a_fault: assert property (p_fault) else $error("fault mute");
   property p_zero_on;
      s_zero_last |=> zero_muted && !mute_output_n;
   endproperty
   a_zero_on: assert property (p_zero_on) else $error("zero on");
   property p_zero_off;
      s_live_muted |=> !zero_muted;
   endproperty
   a_zero_off: assert property (p_zero_off) else $error("unmute");
   property p_zero_cnt;
      $rose(zero_muted) |-> zrun == ccm_pkg::ZERO_LIMIT;
   endproperty
   a_zero_cnt: assert property (p_zero_cnt) else $error("run cnt");
endmodule : ccm_core_monitor
bind ccm_core ccm_core_monitor u_mon (.clk, .rst_b, .clk_cfg, .mclk_present,
   .power_down, .soft_mute, .zero_mute_enable, .dac_frame,
   .frame_select_clock_oe_n, .bit_clock_oe_n, .port_mode,
   .control_data_oe_n, .address_select_lsb, .bus_address, .zero_muted,
   .mute_output_n);
`default_nettype wire

/* ccm_host_model.sv */
/*
 host model: slave frame clock made from the master clock.
 assumes period is given in master clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module ccm_host_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [9:0] period,
   output logic frame_clk
);
   logic [9:0] cnt;
   logic [9:0] next_cnt;
   // low half first; stands low when idle
   always_comb begin
      next_cnt = (cnt + 10'h001 >= period) ? 10'h000 : cnt + 10'h001;
      if (!run) begin
         next_cnt = 10'h000;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 10'h000;
      end else begin
         cnt <= next_cnt;
      end
   end
   assign frame_clk = run && (cnt >= (period >> 1));
endmodule : ccm_host_model
`default_nettype wire

/* ccm_core_tb.sv */
/*
 testbench for ccm_core: strap, control pins, ratios, mute causes.
 assumes the host model and the bound monitor.
*/
`timescale 1ns/100ps
`default_nettype none
module ccm_core_tb;
   logic clk, rst_b, mclk_ok, pwr_ok, pwr_dn, smute, zen, strap, asel;
   logic cpclk, drv_low, run, fclk_in, fclk_oe_n, pair, ae_n, cdo;
   logic cdo_oe_n, samp, cp_en, core_en, low_pwr, rerr, zm, mute_n;
   logic fclk_out, bclk, bclk_oe_n, fleft;
   logic [9:0] period;
   logic [6:0] addr;
   ccm_pkg::ccm_clk_cfg_t cfg;
   ccm_pkg::ccm_frame_t frm;
   ccm_pkg::ccm_port_mode_t pmode;
   int n_fail, checks, n_pair, n_samp;
   wire logic dline = cdo_oe_n ? 1'b1 : cdo; // pull-up
   ccm_core u_dut (.clk(clk), .rst_b(rst_b), .clk_cfg(cfg),
      .mclk_present(mclk_ok), .frame_select_clock_in(fclk_in),
      .frame_select_clock_out(fclk_out),
      .frame_select_clock_oe_n(fclk_oe_n), .bit_clock_out(bclk),
      .bit_clock_oe_n(bclk_oe_n), .frame_left(fleft),
      .pair_strobe(pair), .audio_serial_out_in(strap),
      .audio_serial_out_oe_n(ae_n), .port_mode(pmode),
      .control_port_clock(cpclk), .control_data_in(dline),
      .control_data_drive_low(drv_low), .control_data_out(cdo),
      .control_data_oe_n(cdo_oe_n), .control_data_sample(samp),
      .address_select_lsb(asel), .bus_address(addr),
      .control_port_enable(cp_en), .core_enable(core_en),
      .low_power(low_pwr), .power_up_done(pwr_ok), .power_down(pwr_dn),
      .soft_mute(smute), .zero_mute_enable(zen), .dac_frame(frm),
      .ratio_error(rerr), .zero_muted(zm), .mute_output_n(mute_n));
   ccm_host_model u_host (.clk(clk), .rst_b(rst_b), .run(run),
      .period(period), .frame_clk(fclk_in));
   task automatic chk(input string nm, input logic [9:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic at_neg(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : at_neg
   task automatic t_reset(input logic s);
      @(posedge clk) rst_b <= 1'b0;
      strap <= s;
      @(negedge clk);
      chk("mute", mute_n, 1'b0);
      chk("lowp", low_pwr, 1'b1);
      chk("mode", pmode, 1'b0);
      chk("strap_oe", ae_n, 1'b1);
      @(posedge clk) rst_b <= 1'b1;
      // strap flips at the first edge after release: must not count
      @(posedge clk) strap <= ~s;
      at_neg(2);
      chk("mode", pmode, s);
      chk("core", core_en, 1'b1);
      chk("lowp", low_pwr, 1'b0);
   endtask : t_reset
   task automatic t_port;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) {asel, drv_low} <= k[1:0];
         at_neg(2);
         n_samp = 0;
         @(posedge clk) cpclk <= 1'b1;
         at_neg(4);
         if (pmode === ccm_pkg::CCM_TWO_WIRE) begin
            chk("addr", addr, {ccm_pkg::ADDR_BASE[6:1], k[1]});
            chk("line", dline, !k[0]);
            chk("samp", n_samp, 1);
         end else begin
            chk("line_oe", cdo_oe_n, 1'b1);
            chk("cs", cp_en, !k[1]);
            chk("samp", n_samp, !k[1]);
         end
         @(posedge clk) cpclk <= 1'b0;
      end
      @(posedge clk) {asel, drv_low} <= 2'b00;
   endtask : t_port
   task automatic t_ratio;
      logic [9:0] tbl [8] = '{ccm_pkg::BRM_R0, ccm_pkg::BRM_R1,
         ccm_pkg::BRM_R2, ccm_pkg::BRM_R3, ccm_pkg::HRM_R0,
         ccm_pkg::HRM_R1, ccm_pkg::HRM_R2, ccm_pkg::HRM_R3};
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) cfg.high_rate_mode <= i[2];
         cfg.clock_ratio_select <= i[1:0];
         period <= tbl[i];
         run <= 1'b1;
         repeat (4 * tbl[i]) @(posedge clk);
         @(negedge clk) n_pair = 0;
         at_neg(2 * tbl[i]);
         chk("pairs", n_pair, 2);
         chk("rerr", rerr, 1'b0);
         chk("mute", mute_n, 1'b1);
      end
      @(posedge clk) period <= ccm_pkg::BRM_R0;
      at_neg(1024);
      chk("rerr", rerr, 1'b1);
      chk("mute", mute_n, 1'b0);
      @(posedge clk) cfg.clock_ratio_select <= ccm_pkg::RATIO_1;
      cfg.high_rate_mode <= 1'b0;
      period <= ccm_pkg::BRM_R1;
      at_neg(1536);
   endtask : t_ratio
   task automatic t_mute;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) {smute, mclk_ok, pwr_ok, pwr_dn} <= 4'h6 ^ (4'h8 >> k);
         at_neg(2);
         chk("mute", mute_n, 1'b0);
         @(posedge clk) {smute, mclk_ok, pwr_ok, pwr_dn} <= 4'h6;
         at_neg(1100);
         chk("mute", mute_n, 1'b1);
      end
   endtask : t_mute
   task automatic t_zero(input logic en);
      @(posedge clk) zen <= en;
      frm.valid <= 1'b1;
      at_neg(511);
      chk("zm", zm, 1'b0);
      at_neg(1);
      chk("zm", zm, en);
      chk("mute", mute_n, !en);
      @(posedge clk) frm.data[5] <= 24'h00_0001;
      at_neg(1);
      chk("zm", zm, 1'b0);
      chk("mute", mute_n, 1'b1);
      @(posedge clk) frm <= '0;
   endtask : t_zero
   task automatic t_master;
      int hi, lf, br;
      logic bp;
      @(posedge clk) cfg.master_mode <= 1'b1;
      cfg.bit_clock_div <= 8'h01;
      at_neg(2);
      chk("fclk_oe", fclk_oe_n, 1'b0);
      chk("bclk_oe", bclk_oe_n, 1'b0);
      // let the first master frames settle before measuring one frame
      at_neg(1024);
      hi = 0;
      lf = 0;
      br = 0;
      bp = bclk;
      repeat (ccm_pkg::BRM_R1) begin
         hi += fclk_out;
         lf += fleft;
         br += bclk && !bp;
         bp = bclk;
         at_neg(1);
      end
      chk("fclk_hi", hi, ccm_pkg::BRM_R1 >> 1);
      chk("left", lf, ccm_pkg::BRM_R1 >> 1);
      // divider 1: two clocks a half period, four a bit
      chk("bclk", br, ccm_pkg::BRM_R1 >> 2);
      chk("rerr", rerr, 1'b0);
      chk("mute", mute_n, 1'b1);
   endtask : t_master
   task automatic tally_and_finish;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (pair === 1'b1) n_pair++;
      if (samp === 1'b1) n_samp++;
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      {rst_b, pwr_dn, smute, zen, strap, asel, drv_low, run} = '0;
      {mclk_ok, pwr_ok} = 2'b11;
      cpclk = 1'b0; // idle through reset
      cfg = '0;
      frm = '0;
      period = ccm_pkg::BRM_R1;
      {n_fail, checks, n_pair, n_samp} = '0;
      t_reset(1'b1);
      t_port;
      t_reset(1'b0);
      t_port;
      t_ratio;
      t_mute;
      t_zero(1'b1);
      t_zero(1'b0);
      t_master;
      tally_and_finish;
   end
endmodule : ccm_core_tb
`default_nettype wire
